// >>> hdl/rsspwm_top.sv
// Two pulse-width outputs driven from packet strength or passed analog samples.
// Assumes packet events are one-cycle pulses from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rsspwm_top
#(
    parameter int TICK_CYCLES = rsspwm_pkg::TICK_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Settings
    input wire logic [1:0] firstOutputFunctionSelect,
    input wire logic [1:0] secondOutputFunctionSelect,
    input wire logic [7:0] passedValueOutputTimeout,
    input wire logic [7:0] strengthOutputHoldTime,
    input wire logic [15:0] ioInputSourceAddress,
    // Received packet
    input wire logic pktValid,
    input wire logic signed [7:0] pktDbAbove,
    // Received I/O sample packet
    input wire logic sampleValid,
    input wire logic [15:0] sampleSource,
    input wire logic [9:0] firstAnalogSample,
    input wire logic [9:0] secondAnalogSample,
    // Pins and status
    output logic firstPulseOutput,
    output logic secondPulseOutput,
    output logic passTimedOut
);
    // ==========================================================
    // Step counter and 100 ms tick
    logic [8:0] step_q;
    logic [8:0] step_d;
    logic [7:0] stepAcc_q;
    logic [7:0] stepAcc_d;
    logic stepEn;
    logic [31:0] tickCnt_q;
    logic [31:0] tickCnt_d;
    logic tick;

    always_comb
    begin
        // A step every 144 ns on average: 7 or 8 clocks, so 445 steps make about 64 us
        stepEn = (stepAcc_q >= rsspwm_pkg::STEP_ACC_TOP);
        if (stepEn)
            stepAcc_d = stepAcc_q - rsspwm_pkg::STEP_ACC_TOP;
        else
            stepAcc_d = stepAcc_q + rsspwm_pkg::STEP_ACC_INC;
        step_d = step_q;
        if (stepEn)
            step_d = (step_q == rsspwm_pkg::STEP_LAST) ? 9'h000 : step_q + 9'h001;
        tick = (tickCnt_q == 32'(TICK_CYCLES - 1));
        tickCnt_d = tick ? 32'h0 : tickCnt_q + 32'h1;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            step_q <= 9'h000;
            stepAcc_q <= 8'h00;
            tickCnt_q <= 32'h0;
        end
        else
        begin
            step_q <= step_d;
            stepAcc_q <= stepAcc_d;
            tickCnt_q <= tickCnt_d;
        end
    end

    // ==========================================================
    // Strength capture and hold timer
    logic [8:0] strDuty_q;
    logic [8:0] strDuty_d;
    logic strShow_q;
    logic strShow_d;
    logic [7:0] holdCnt_q;
    logic [7:0] holdCnt_d;

    always_comb
    begin
        strDuty_d = strDuty_q;
        strShow_d = strShow_q;
        holdCnt_d = holdCnt_q;
        if (pktValid)
        begin
            strDuty_d = rsspwm_pkg::strengthDuty(pktDbAbove);
            strShow_d = 1'b1;
            holdCnt_d = strengthOutputHoldTime;
        end
        else if (tick && strShow_q && strengthOutputHoldTime != rsspwm_pkg::HOLD_FOREVER)
        begin
            if (holdCnt_q <= 8'h01)
                strShow_d = 1'b0;
            else
                holdCnt_d = holdCnt_q - 8'h01;
        end
        if (strengthOutputHoldTime == 8'h00)
            strShow_d = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strDuty_q <= 9'h000;
            strShow_q <= 1'b0;
            holdCnt_q <= rsspwm_pkg::HOLD_RST;
        end
        else
        begin
            strDuty_q <= strDuty_d;
            strShow_q <= strShow_d;
            holdCnt_q <= holdCnt_d;
        end
    end

    // ==========================================================
    // Passed-value duties and shared timeout
    logic [8:0] passDuty0_q;
    logic [8:0] passDuty0_d;
    logic [8:0] passDuty1_q;
    logic [8:0] passDuty1_d;
    logic [7:0] passCnt_q;
    logic [7:0] passCnt_d;
    logic tmo_q;
    logic tmo_d;
    logic srcMatch;

    always_comb
    begin
        srcMatch = sampleValid && (sampleSource == ioInputSourceAddress);
        passDuty0_d = passDuty0_q;
        passDuty1_d = passDuty1_q;
        passCnt_d = passCnt_q;
        tmo_d = 1'b0;
        if (srcMatch)
        begin
            if (firstOutputFunctionSelect == rsspwm_pkg::SEL_PASSED)
                passDuty0_d = rsspwm_pkg::sampleDuty(firstAnalogSample);
            if (secondOutputFunctionSelect == rsspwm_pkg::SEL_PASSED)
                passDuty1_d = rsspwm_pkg::sampleDuty(secondAnalogSample);
        end
        if (sampleValid)
            passCnt_d = passedValueOutputTimeout;
        else if (tick && (passDuty0_q != 9'h000 || passDuty1_q != 9'h000))
        begin
            // Zero timeout forces the duty off on the next tick
            if (passCnt_q <= 8'h01)
            begin
                passDuty0_d = 9'h000;
                passDuty1_d = 9'h000;
                tmo_d = 1'b1;
            end
            else
                passCnt_d = passCnt_q - 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            passDuty0_q <= 9'h000;
            passDuty1_q <= 9'h000;
            passCnt_q <= rsspwm_pkg::PASS_TMO_RST;
            tmo_q <= 1'b0;
        end
        else
        begin
            passDuty0_q <= passDuty0_d;
            passDuty1_q <= passDuty1_d;
            passCnt_q <= passCnt_d;
            tmo_q <= tmo_d;
        end
    end

    // ==========================================================
    // Output selection
    function automatic logic [8:0] pickDuty(input logic [1:0] sel, input logic [8:0] passed,
                                            input logic [8:0] strength, input logic show);
        logic [8:0] d;
        d = 9'h000;
        unique case (sel)
            rsspwm_pkg::SEL_STRENGTH: d = show ? strength : 9'h000;
            rsspwm_pkg::SEL_PASSED: d = passed;
            default: d = 9'h000;
        endcase
        return d;
    endfunction

    rsspwm_if firstLink();
    rsspwm_if secondLink();

    assign firstLink.step = step_q;
    assign secondLink.step = step_q;
    assign firstLink.duty = pickDuty(firstOutputFunctionSelect, passDuty0_q, strDuty_q,
                                     strShow_q);
    assign secondLink.duty = pickDuty(secondOutputFunctionSelect, passDuty1_q, strDuty_q,
                                      strShow_q);

    rsspwm_gen gen0
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pwm(firstLink),
        .pinOut(firstPulseOutput)
    );

    rsspwm_gen gen1
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pwm(secondLink),
        .pinOut(secondPulseOutput)
    );

    assign passTimedOut = tmo_q;
endmodule
`default_nettype wire

// >>> hdl/rsspwm_pkg.sv
// Shared constants for the strength and passed-value pulse outputs.
// Assumes a 50 MHz ref_clk.
package rsspwm_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_NS = 20;
    localparam int PERIOD_NS = 64000;
    localparam int STEP_NS = 144;
    localparam int STEPS = 445;
    localparam int TICK_MS = 100;
    // Cycles per 100 ms unit; above 4096 so the top exposes it as a parameter
    localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
    // Step counter advances once per 144 ns on average, period wraps at STEPS
    localparam logic [8:0] STEP_LAST = 9'(STEPS - 1);
    // Fractional step divider: add one clock period, take a step past the top
    localparam logic [7:0] STEP_ACC_INC = 8'(CLK_NS);
    localparam logic [7:0] STEP_ACC_TOP = 8'(STEP_NS - CLK_NS);
    // ==========================================================
    // Reset values of the settings, and the hold setting that never expires
    localparam logic [1:0] FIRST_SEL_RST = 2'h1;
    localparam logic [1:0] SECOND_SEL_RST = 2'h0;
    localparam logic [7:0] PASS_TMO_RST = 8'hff;
    localparam logic [7:0] HOLD_RST = 8'h28;
    localparam logic [7:0] HOLD_FOREVER = 8'hff;
    // ==========================================================
    // Strength duty map: steps at sensitivity, steps lost per dB below it,
    // and above it a level in tenths of a percent rising per dB
    localparam logic [8:0] DUTY_AT_SENS = 9'h06b;
    localparam logic [8:0] DUTY_PER_DB = 9'h004;
    localparam int SENS_PERMILLE = 240;
    localparam int PERMILLE_PER_DB = 17;
    localparam int PERMILLE_FULL = 1000;
    // ==========================================================
    typedef enum logic [1:0]
    {
        SEL_OFF = 2'b00,
        SEL_STRENGTH = 2'b01,
        SEL_PASSED = 2'b10
    } rsspwm_sel_e;

    // Duty in steps for a level in dB above sensitivity (negative: below)
    function automatic logic [8:0] strengthDuty(input logic signed [7:0] dbAbove);
        logic [23:0] dutyWide;
        dutyWide = 24'h0;
        if (dbAbove <= 8'sd0)
        begin
            // 1..24 percent, linear from -24 dB up to sensitivity
            if (dbAbove < -8'sd24)
                dutyWide = 24'h000005;
            else
                dutyWide = 24'(DUTY_AT_SENS) - 24'(DUTY_PER_DB) * 24'(-dbAbove);
        end
        else
        begin
            // 24 percent at sensitivity plus 1.7 percent per dB, capped at full
            dutyWide = 24'(SENS_PERMILLE) + 24'(PERMILLE_PER_DB) * 24'(dbAbove[6:0]);
            if (dutyWide > 24'(PERMILLE_FULL))
                dutyWide = 24'(PERMILLE_FULL);
            dutyWide = dutyWide * 24'(STEPS) / 24'(PERMILLE_FULL);
        end
        return dutyWide[8:0];
    endfunction

    // Scale a 10-bit analog sample to duty steps
    function automatic logic [8:0] sampleDuty(input logic [9:0] sample);
        logic [19:0] prod;
        prod = 20'(sample) * 20'(STEPS);
        return prod[18:10];
    endfunction
endpackage

// >>> hdl/rsspwm_if.sv
// Duty and step bundle handed from the control logic to a pulse generator.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface rsspwm_if;
    logic [8:0] duty;
    logic [8:0] step;
    modport ctrl (output duty, output step);
    modport gen (input duty, input step);
endinterface
`default_nettype wire

// >>> hdl/rsspwm_gen.sv
// One pulse output: high while the shared step count is below the duty.
// Assumes step wraps over the period and duty never exceeds STEPS.
`timescale 1ns/1ps
`default_nettype none
module rsspwm_gen
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Duty and step
    rsspwm_if.gen pwm,
    // Pin
    output logic pinOut
);
    logic pin_d;
    logic pin_q;

    always_comb
    begin
        pin_d = (pwm.step < pwm.duty);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pin_q <= 1'b0;
        else
            pin_q <= pin_d;
    end

    assign pinOut = pin_q;
endmodule
`default_nettype wire

// >>> verif/rsspwm_properties.sv
// Timing checks on the pins of the pulse output block.
// Assumes TICK_CYCLES of at least 10 in simulation.
`timescale 1ns/1ps
`default_nettype none
module rsspwm_properties
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Settings and events
    input wire logic [1:0] firstOutputFunctionSelect,
    input wire logic [1:0] secondOutputFunctionSelect,
    input wire logic [7:0] passedValueOutputTimeout,
    input wire logic [7:0] strengthOutputHoldTime,
    input wire logic pktValid,
    input wire logic signed [7:0] pktDbAbove,
    input wire logic sampleValid,
    // Pins
    input wire logic firstPulseOutput,
    input wire logic secondPulseOutput,
    input wire logic passTimedOut
);
    wire [1:0] s0 = firstOutputFunctionSelect;
    wire [1:0] s1 = secondOutputFunctionSelect;
    wire o0 = firstPulseOutput;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    first_off_low_a: assert property ((s0 == 2'h0)[*4] |-> !o0)
        else $error("first pin high while off");
    second_off_low_a: assert property ((s1[0] == s1[1])[*4] |-> !secondPulseOutput)
        else $error("second pin high while off");
    hold_zero_low_a: assert property ((s0 == 2'h1 && strengthOutputHoldTime == 8'h0)[*4] |-> !o0)
        else $error("strength pin high with zero hold");
    restart_no_tmo_a: assert property (sampleValid && passedValueOutputTimeout > 8'h1 |=> !passTimedOut[*8])
        else $error("timeout soon after a sample");
    tmo_single_pulse_a: assert property (passTimedOut |=> !passTimedOut)
        else $error("timeout pulse too long");
    tmo_needs_pass_a: assert property (passTimedOut |-> $past(s0 == 2'h2 || s1 == 2'h2))
        else $error("timeout without passed mode");
    tmo_forces_low_a: assert property (passTimedOut && !sampleValid ##1 !sampleValid[*3] |-> !(s0 == 2'h2 && o0))
        else $error("passed pin high after timeout");
    // Above 27 dB the low part of a 3204-clock period stays below 1000 clocks
    strength_shows_a: assert property (pktValid && pktDbAbove > 8'sd27
        && strengthOutputHoldTime == 8'hff ##1 (s0 == 2'h1 && !pktValid)[*3] |-> ##[0:1000] o0)
        else $error("strength pin never high");
    reset_low_a: assert property ($rose(resetn) |-> !o0 && !secondPulseOutput)
        else $error("pin high after reset");
endmodule
bind rsspwm_top rsspwm_properties rsspwm_properties_inst (.ref_clk(ref_clk), .resetn(resetn),
    .firstOutputFunctionSelect(firstOutputFunctionSelect),
    .secondOutputFunctionSelect(secondOutputFunctionSelect),
    .passedValueOutputTimeout(passedValueOutputTimeout),
    .strengthOutputHoldTime(strengthOutputHoldTime), .pktValid(pktValid),
    .pktDbAbove(pktDbAbove), .sampleValid(sampleValid), .firstPulseOutput(firstPulseOutput),
    .secondPulseOutput(secondPulseOutput), .passTimedOut(passTimedOut));
`default_nettype wire

// >>> verif/rsspwm_remote.sv
// Remote radio: sends packets and I/O samples as one-cycle events.
// Assumes the bench calls its tasks; released data lines show garbage.
`timescale 1ns/1ps
`default_nettype none
module rsspwm_remote
(
    // Clock
    input wire logic ref_clk,
    // Events
    output logic pktValid,
    output logic signed [7:0] pktDbAbove,
    output logic sampleValid,
    output logic [15:0] sampleSource,
    output logic [9:0] firstAnalogSample,
    output logic [9:0] secondAnalogSample
);
    initial
    begin
        pktValid = 1'b0;
        sampleValid = 1'b0;
        pktDbAbove = 8'sh0;
        sampleSource = 16'h0;
        firstAnalogSample = 10'h0;
        secondAnalogSample = 10'h0;
    end
    task automatic sendPkt(input logic signed [7:0] db);
        @(posedge ref_clk) #1;
        pktValid = 1'b1;
        pktDbAbove = db;
        @(posedge ref_clk) #1;
        pktValid = 1'b0;
        pktDbAbove = ~db;
    endtask
    task automatic sendSample(input logic [15:0] src, input logic [9:0] a0, input logic [9:0] a1);
        @(posedge ref_clk) #1;
        sampleValid = 1'b1;
        {sampleSource, firstAnalogSample, secondAnalogSample} = {src, a0, a1};
        @(posedge ref_clk) #1;
        sampleValid = 1'b0;
        {sampleSource, firstAnalogSample, secondAnalogSample} = ~{src, a0, a1};
    endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench: measures pin duty over whole periods.
// Assumes TICK_CYCLES shortened to 20 clocks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TK = 20;
    localparam int P = rsspwm_pkg::STEPS;
    // Clocks in one full period of 445 steps of 144 ns
    localparam int PC = P * rsspwm_pkg::STEP_NS / rsspwm_pkg::CLK_NS;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] fSel = 2'h1;
    logic [1:0] sSel = 2'h0;
    logic [7:0] passTmo = 8'hff;
    logic [7:0] holdTime = 8'h28;
    logic [15:0] addr = 16'h1234;
    logic pktValid, sampleValid, pin0, pin1, tmo;
    logic signed [7:0] db;
    logic [15:0] src;
    logic [9:0] an0, an1, a0, a1;
    logic [31:0] seed = 32'd86554;
    int n_mismatch = 0;
    int checks_done = 0;
    int hi0, hi1, k;
    int tmoSeen = 0;
    rsspwm_top #(.TICK_CYCLES(TK)) rsspwm_top_inst (.ref_clk(ref_clk), .resetn(resetn),
        .firstOutputFunctionSelect(fSel), .secondOutputFunctionSelect(sSel),
        .passedValueOutputTimeout(passTmo), .strengthOutputHoldTime(holdTime),
        .ioInputSourceAddress(addr), .pktValid(pktValid), .pktDbAbove(db),
        .sampleValid(sampleValid), .sampleSource(src), .firstAnalogSample(an0),
        .secondAnalogSample(an1), .firstPulseOutput(pin0), .secondPulseOutput(pin1),
        .passTimedOut(tmo));
    rsspwm_remote rsspwm_remote_inst (.ref_clk(ref_clk), .pktValid(pktValid), .pktDbAbove(db),
        .sampleValid(sampleValid), .sampleSource(src), .firstAnalogSample(an0),
        .secondAnalogSample(an1));
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk)
    begin
        if (tmo === 1'b1)
            tmoSeen++;
    end
    function automatic int rnd(input int lim);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % lim);
    endfunction
    // One percent of tolerance on a period count
    function automatic int near(input int seen, input int exp);
        return int'(seen >= exp - 5 && seen <= exp + 5);
    endfunction
    task automatic check(input string what, input int exp, input int seen);
        checks_done++;
        if (seen != exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic measure();
        hi0 = 0;
        hi1 = 0;
        repeat (PC)
        begin
            tick(1);
            hi0 += int'(pin0 === 1'b1);
            hi1 += int'(pin1 === 1'b1);
        end
        // High clocks back to duty steps, rounded; a step lasts 7 or 8 clocks
        hi0 = (hi0 * rsspwm_pkg::CLK_NS + rsspwm_pkg::STEP_NS / 2) / rsspwm_pkg::STEP_NS;
        hi1 = (hi1 * rsspwm_pkg::CLK_NS + rsspwm_pkg::STEP_NS / 2) / rsspwm_pkg::STEP_NS;
    endtask
    task automatic pkt(input int d);
        rsspwm_remote_inst.sendPkt(8'(d));
        measure();
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        tick(4);
        resetn = 1'b1;
        measure();
        check("first idle", 0, hi0);
        check("second default", 0, hi1);
        holdTime = 8'hff;
        for (int i = 0; i < 3; i++)
        begin
            pkt(10 * i + 10);
            check("strength duty", 1, near(hi0, (17 * i + 41) * P / 100));
        end
        repeat (3)
        begin
            pkt(rnd(40) + 1);
            check("above sens", 1, int'(hi0 >= 24 * P / 100 - 1));
        end
        pkt(-rnd(20));
        check("below sens", 1, int'(hi0 >= 1 && hi0 <= 24 * P / 100 + 1));
        $display("test strength map done");
        sSel = 2'h1;
        pkt(20);
        tick(40 * TK);
        measure();
        check("hold forever", 1, int'(hi0 > 0));
        check("second strength", 1, int'(hi1 > 0));
        holdTime = 8'hc8;
        pkt(30);
        check("hold shows", 1, near(hi0, 75 * P / 100));
        holdTime = 8'h2;
        pkt(30);
        tick(3 * TK + 5);
        measure();
        check("hold expired", 0, hi0);
        holdTime = 8'h0;
        pkt(30);
        check("hold zero", 0, hi0);
        holdTime = 8'hff;
        for (int c = 0; c < 4; c += 3)
        begin
            fSel = 2'(c);
            pkt(30);
            check("first off", 0, hi0);
        end
        $display("test hold and select done");
        fSel = 2'h2;
        sSel = 2'h2;
        a0 = 10'(rnd(1024));
        a1 = 10'(rnd(1024));
        for (int j = 0; j < 2; j++)
        begin
            // Second pass comes from a stranger and must leave both duties alone
            rsspwm_remote_inst.sendSample(addr ^ 16'(j), 10'h3ff - a0, 10'h3ff - a1);
            if (j == 0)
                rsspwm_remote_inst.sendSample(addr, a0, a1);
            measure();
            check("first passed", 1, near(hi0, a0 * P / 1024));
            check("second passed", 1, near(hi1, a1 * P / 1024));
        end
        passTmo = 8'h3;
        tmoSeen = 0;
        repeat (10)
        begin
            rsspwm_remote_inst.sendSample(addr, 10'h200, 10'h200);
            tick(TK);
        end
        check("restart", 0, tmoSeen);
        tick(5 * TK);
        measure();
        check("tmo first", 0, hi0);
        check("tmo second", 0, hi1);
        check("tmo pulse", 1, int'(tmoSeen > 0));
        $display("test passed values done");
        close_out();
    end
    initial
    begin
        tick(80000);
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
